//--- logic/rfdpc_top.v
// Serial-programmed configuration of the main synthesizer loop.
// Assumes serial pins and chip enable are asynchronous to clk; refTick is on clk.
`timescale 1ns/10ps
`default_nettype none
`include "rfdpc_defines.vh"

module rfdpc_top #(
  parameter WORD_W = `RFDPC_WORD_W
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        serClk,
  input  wire        serData,
  input  wire        serLatch,
  input  wire        chipEnable,
  input  wire        refTick,
  output reg  [5:0]  mainCoarseCount,
  output reg  [2:0]  mainQuadCount,
  output reg  [1:0]  mainUnitCount,
  output reg         mainModSpare,
  output reg  [10:0] mainDivision,
  output reg         mainPrescalerSel,
  output reg  [11:0] mainFracNumer,
  output reg  [11:0] mainFracDenom,
  output reg  [5:0]  mainRefDiv,
  output reg         mainRefPulse,
  output reg         mainPowerUp,
  output reg         mainPumpDriveEn,
  output reg  [18:0] auxFeedbackWord,
  output reg         auxPowerUp,
  output reg         freqUpdate
);

  // ==========================================================
  // Pin synchronisers
  reg [2:0]        clkSync;
  reg [1:0]        dataSync;
  reg [2:0]        latchSync;
  reg [1:0]        ceSync;
  reg [WORD_W-1:0] shiftWord;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync   <= 3'h0;
      dataSync  <= 2'h0;
      latchSync <= 3'h0;
      ceSync    <= 2'h0;
    end else begin
      clkSync   <= {clkSync[1:0], serClk};
      dataSync  <= {dataSync[0], serData};
      latchSync <= {latchSync[1:0], serLatch};
      ceSync    <= {ceSync[0], chipEnable};
    end
  end

  wire serRise   = clkSync[1] & ~clkSync[2];
  wire latchRise = latchSync[1] & ~latchSync[2];
  wire ceLevel   = ceSync[1];

  // Bits shift in most significant first; nothing takes effect until the latch edge.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftWord <= {WORD_W{1'b0}};
    end else if (serRise) begin
      shiftWord <= {shiftWord[WORD_W-2:0], dataSync[1]};
    end
  end

  // ==========================================================
  // Word decode
  function isCode;
    input [3:0] code;
    input [3:0] want;
    begin
      isCode = (code == want);
    end
  endfunction

  wire [3:0] code      = shiftWord[3:0];
  wire       freqWrite = latchRise & ((code & `RFDPC_CODE_FREQ_MASK) == `RFDPC_CODE_FREQ);
  wire       mainWrite = latchRise & isCode(code, `RFDPC_CODE_MAIN);
  wire       auxWrite  = latchRise & isCode(code, `RFDPC_CODE_AUX);
  wire       wakeWrite = latchRise & isCode(code, `RFDPC_CODE_WAKE);

  // ==========================================================
  // Configuration registers
  reg [10:0] nWord;
  reg        mainSleep;
  reg        auxSleep;
  reg        autoWake;
  reg        wakeHeld;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nWord            <= 11'h000;
      mainFracNumer    <= 12'h000;
      mainFracDenom    <= 12'h000;
      mainRefDiv       <= `RFDPC_RST_REF;
      mainPrescalerSel <= `RFDPC_RST_ZERO;
      mainSleep        <= `RFDPC_RST_SLEEP;
      auxFeedbackWord  <= 19'h00000;
      auxSleep         <= `RFDPC_RST_SLEEP;
      autoWake         <= `RFDPC_RST_ZERO;
      wakeHeld         <= `RFDPC_RST_ZERO;
      freqUpdate       <= 1'b0;
    end else begin
      freqUpdate <= freqWrite;
      if (freqWrite) begin
        nWord         <= shiftWord[`RFDPC_NWORD_HI:`RFDPC_NWORD_LO];
        mainFracNumer <= shiftWord[`RFDPC_NUMER_HI:`RFDPC_NUMER_LO];
      end
      if (mainWrite) begin
        mainSleep        <= shiftWord[`RFDPC_MSLEEP_BIT];
        mainPrescalerSel <= shiftWord[`RFDPC_PSEL_BIT];
        mainRefDiv       <= shiftWord[`RFDPC_REF_HI:`RFDPC_REF_LO];
        mainFracDenom    <= shiftWord[`RFDPC_DENOM_HI:`RFDPC_DENOM_LO];
      end
      if (auxWrite) begin
        auxFeedbackWord <= shiftWord[`RFDPC_AUXN_HI:`RFDPC_AUXN_LO];
      end
      // A wake-up frequency write wins over a same-edge sleep write.
      if (freqWrite && autoWake) begin
        auxSleep <= 1'b0;
      end else if (auxWrite) begin
        auxSleep <= shiftWord[`RFDPC_ASLEEP_BIT];
      end
      if (wakeWrite) begin
        autoWake <= shiftWord[`RFDPC_WAKE_BIT];
      end
      // The wake request stands until software issues a fresh main word or a wake word with the wake bit clear.
      if (freqWrite && autoWake) begin
        wakeHeld <= 1'b1;
      end else if (mainWrite || (wakeWrite && !shiftWord[`RFDPC_WAKE_BIT])) begin
        wakeHeld <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Feedback split and power precedence
  wire [5:0]  splitCoarse;
  wire [2:0]  splitQuad;
  wire [1:0]  splitUnit;
  wire        splitSpare;
  wire [10:0] splitDivision;

  rfdpc_n_split u_split (
    .nWord        (nWord),
    .prescalerSel (mainPrescalerSel),
    .coarseCount  (splitCoarse),
    .quadCount    (splitQuad),
    .unitCount    (splitUnit),
    .modSpare     (splitSpare),
    .division     (splitDivision)
  );

  wire next_mainPowerUp = ceLevel & (wakeHeld | ~mainSleep);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mainCoarseCount <= 6'h00;
      mainQuadCount   <= 3'h0;
      mainUnitCount   <= 2'h0;
      mainModSpare    <= 1'b0;
      mainDivision    <= 11'h000;
      mainPowerUp     <= 1'b0;
      mainPumpDriveEn <= 1'b0;
      auxPowerUp      <= 1'b0;
    end else begin
      mainCoarseCount <= splitCoarse;
      mainQuadCount   <= splitQuad;
      mainUnitCount   <= splitUnit;
      mainModSpare    <= splitSpare;
      mainDivision    <= splitDivision;
      mainPowerUp     <= next_mainPowerUp;
      mainPumpDriveEn <= next_mainPowerUp;
      auxPowerUp      <= ceLevel & ~auxSleep;
    end
  end

  // ==========================================================
  // Reference divider
  // A zero setting is treated as one so the divider never stalls.
  reg [5:0] refCount;
  wire [5:0] refLimit = (mainRefDiv == 6'h00) ? 6'h01 : mainRefDiv;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refCount     <= 6'h00;
      mainRefPulse <= 1'b0;
    end else begin
      mainRefPulse <= 1'b0;
      if (refTick && mainPowerUp) begin
        if (refCount >= refLimit - 6'h01) begin
          refCount     <= 6'h00;
          mainRefPulse <= 1'b1;
        end else begin
          refCount <= refCount + 6'h01;
        end
      end else if (!mainPowerUp) begin
        refCount <= 6'h00;
      end
    end
  end

endmodule // rfdpc_top
`default_nettype wire

//--- logic/rfdpc_defines.vh
// Constants for the main synthesizer loop configuration block.
// Included by the design files by bare name; definitions only.
`ifndef RFDPC_DEFINES_VH
`define RFDPC_DEFINES_VH

// ==========================================================
// Programming word framing
`define RFDPC_WORD_W         24
`define RFDPC_CODE_W         4
`define RFDPC_CODE_FREQ_MASK 4'h1
`define RFDPC_CODE_FREQ      4'h0
`define RFDPC_CODE_MAIN      4'h3
`define RFDPC_CODE_AUX       4'h5
`define RFDPC_CODE_WAKE      4'hF

// ==========================================================
// Frequency word fields
`define RFDPC_NWORD_HI       23
`define RFDPC_NWORD_LO       13
`define RFDPC_NUMER_HI       12
`define RFDPC_NUMER_LO       1

// ==========================================================
// Main reference, prescaler and denominator word fields
`define RFDPC_MSLEEP_BIT     23
`define RFDPC_PSEL_BIT       22
`define RFDPC_REF_HI         21
`define RFDPC_REF_LO         16
`define RFDPC_DENOM_HI       15
`define RFDPC_DENOM_LO       4

// ==========================================================
// Auxiliary word and wake word fields
`define RFDPC_ASLEEP_BIT     23
`define RFDPC_AUXN_HI        22
`define RFDPC_AUXN_LO        4
`define RFDPC_WAKE_BIT       23

// ==========================================================
// Feedback word split and prescaler moduli
`define RFDPC_COARSE_HI      10
`define RFDPC_COARSE_LO      5
`define RFDPC_QUAD_HI        4
`define RFDPC_QUAD_LO        2
`define RFDPC_UNIT_HI        1
`define RFDPC_UNIT_LO        0
`define RFDPC_QUAD_STEP      11'h004
`define RFDPC_BASE_LOW       11'h010
`define RFDPC_BASE_HIGH      11'h020

// ==========================================================
// Reset values
`define RFDPC_RST_SLEEP      1'b1
`define RFDPC_RST_REF        6'h01
`define RFDPC_RST_ZERO       1'b0

`endif

//--- logic/rfdpc_n_split.v
// Splits the main feedback word into counter fields and forms the division.
// Purely combinational; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none
`include "rfdpc_defines.vh"

module rfdpc_n_split (
  input  wire [10:0] nWord,
  input  wire        prescalerSel,
  output reg  [5:0]  coarseCount,
  output reg  [2:0]  quadCount,
  output reg  [1:0]  unitCount,
  output reg         modSpare,
  output reg  [10:0] division
);

  reg [10:0] base;
  reg [10:0] quadTerm;

  always @* begin
    coarseCount = nWord[`RFDPC_COARSE_HI:`RFDPC_COARSE_LO];
    unitCount   = nWord[`RFDPC_UNIT_HI:`RFDPC_UNIT_LO];
    // The low family uses only two quad bits; the top one goes to the modulator.
    if (prescalerSel) begin
      base      = `RFDPC_BASE_HIGH;
      quadCount = nWord[`RFDPC_QUAD_HI:`RFDPC_QUAD_LO];
      modSpare  = 1'b0;
    end else begin
      base      = `RFDPC_BASE_LOW;
      quadCount = {1'b0, nWord[`RFDPC_QUAD_HI-1:`RFDPC_QUAD_LO]};
      modSpare  = nWord[`RFDPC_QUAD_HI];
    end
    quadTerm = `RFDPC_QUAD_STEP * {8'h00, quadCount};
    // Result stays within eleven bits for every field value.
    division = (base == `RFDPC_BASE_HIGH ? {coarseCount, 5'h00} : {1'b0, coarseCount, 4'h0})
             + quadTerm + {9'h000, unitCount};
  end

endmodule // rfdpc_n_split
`default_nettype wire

//--- test/rfdpc_checker.sv
// Port assertions for the main loop configuration block.
// Assumes serial pins hold each level three clocks or more.
`timescale 1ns/10ps
`default_nettype none
module rfdpc_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        serLatch,
  input wire logic        chipEnable,
  input wire logic        refTick,
  input wire logic [5:0]  mainCoarseCount,
  input wire logic [2:0]  mainQuadCount,
  input wire logic [1:0]  mainUnitCount,
  input wire logic        mainModSpare,
  input wire logic [10:0] mainDivision,
  input wire logic        mainPrescalerSel,
  input wire logic [5:0]  mainRefDiv,
  input wire logic        mainRefPulse,
  input wire logic        mainPowerUp,
  input wire logic        mainPumpDriveEn,
  input wire logic        freqUpdate
);
  // ====================
  // Relations
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_DIV: assert property ($stable(mainPrescalerSel) |-> mainDivision ==
    (mainPrescalerSel ? 11'h020 : 11'h010) * mainCoarseCount + 11'h004 * mainQuadCount + mainUnitCount)
    else $error("division wrong");
  AST_SPARE: assert property ($stable(mainPrescalerSel) |->
    (mainPrescalerSel ? !mainModSpare : !mainQuadCount[2])) else $error("spare bit wrong");
  AST_PUMP: assert property (mainPumpDriveEn == mainPowerUp) else $error("pump enable wrong");
  AST_CE: assert property (!chipEnable [*5] |-> !mainPowerUp) else $error("powered while disabled");
  AST_FPULSE: assert property (freqUpdate |=> !freqUpdate) else $error("update pulse long");
  AST_FSRC: assert property ($rose(freqUpdate) |-> $past(serLatch, 3)) else $error("update without latch");
  AST_REF: assert property (mainRefPulse |-> $past(refTick) && $past(mainPowerUp))
    else $error("stray reference pulse");
  AST_HOLD: assert property ($changed(mainRefDiv) |-> $past(serLatch, 2))
    else $error("field moved without latch");
endmodule // rfdpc_checker
bind rfdpc_top rfdpc_checker chk (.*);
`default_nettype wire

//--- test/rfdpc_host.sv
// Host model shifting 24-bit programming words, MSB first.
// Assumes the bench holds go and word until done.
`timescale 1ns/10ps
`default_nettype none
module rfdpc_host (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [23:0] word,
  output var  logic        serClk,
  output var  logic        serData,
  output var  logic        serLatch,
  output var  logic        done
);
  // ====================
  // Shifter
  // Four clocks per level, so the three-clock synchronizer never misses one.
  // One process owns every pin, so no pin has two drivers.
  initial begin
    serClk = 0;
    serData = 0;
    serLatch = 0;
    done = 0;
    forever begin
      @(posedge clk);
      if (go && !done) begin
        for (int i = 23; i >= 0; i--) begin
          #1 serData = word[i];
          serClk = 0;
          repeat (4) @(posedge clk);
          #1 serClk = 1;
          repeat (4) @(posedge clk);
        end
        #1 serClk = 0;
        serData = !serData;
        serLatch = 1;
        repeat (4) @(posedge clk);
        #1 serLatch = 0;
        repeat (4) @(posedge clk);
        #1 done = 1;
        @(posedge clk);
        #1 done = 0;
      end
    end
  end
endmodule // rfdpc_host
`default_nettype wire

//--- test/rfdpc_top_bench.sv
// Self-checking bench for the main loop configuration block.
// Assumes rfdpc_host drives the serial pins.
`timescale 1ns/10ps
`default_nettype none
module rfdpc_top_bench;
  logic        clk = 0, rst_n = 0, chipEnable = 1, refTick = 0, go = 0;
  logic        serClk, serData, serLatch, done, mainModSpare, mainPrescalerSel, mainRefPulse;
  logic        mainPowerUp, mainPumpDriveEn, auxPowerUp, freqUpdate;
  logic [5:0]  mainCoarseCount, mainRefDiv;
  logic [2:0]  mainQuadCount;
  logic [1:0]  mainUnitCount;
  logic [10:0] mainDivision;
  logic [11:0] mainFracNumer, mainFracDenom;
  logic [18:0] auxFeedbackWord;
  logic [23:0] word = 0;
  logic [23:0] q[$];
  logic [10:0] fq[$];
  logic        updSeen = 0;
  logic [31:0] rng = 32'h77C1, r;
  int          errors = 0, comparisons = 0, cyc = 0, pulses = 0;
  int          nList[7] = '{49, 80, 1023, 97, 231, 2039, 2045};
  rfdpc_top dut (.*);
  rfdpc_host host (.*);
  initial forever #12.5 clk = ~clk;
  // ====================
  // Helpers
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [23:0] w);
    @(posedge clk);
    #1 word = w;
    go = 1;
    @(posedge done);
    #1 go = 0;
  endtask
  task automatic freq(input int n, input logic hi);
    r = xs();
    q.push_back({hi ? 1'b0 : r[12], n[10:0], r[11:0]});
    fq.push_back(hi ? n[10:0] : {n[9:4], 1'b0, n[3:0]});
    send({hi ? n[10:0] : {n[9:4], r[12], n[3:0]}, r[11:0], 1'b0});
  endtask
  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge clk) begin
    pulses = pulses + int'(mainRefPulse);
    // The counter fields settle one cycle after the update strobe, so compare on the next falling edge.
    if (updSeen) begin
      check({mainModSpare, mainDivision, mainFracNumer}, q.pop_front());
      check(24'({mainCoarseCount, mainQuadCount, mainUnitCount}), 24'(fq.pop_front()));
    end
    updSeen = (freqUpdate === 1'b1);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      print_verdict();
    end
  end
  // ====================
  // Scenarios
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    r = xs();
    send({2'b00, 6'h05, r[11:0], 4'h3});
    check({mainPowerUp, mainPumpDriveEn, mainPrescalerSel, mainRefDiv, mainFracDenom}, {3'b110, 6'h05, r[11:0]});
    @(posedge clk);
    #1 refTick = 1;
    repeat (50) @(posedge clk);
    #1 refTick = 0;
    repeat (2) @(posedge clk);
    check(24'(pulses), 24'd10);
    foreach (nList[i]) begin
      if (i == 3) send({2'b01, 6'h05, r[11:0], 4'h3});
      freq(nList[i], i > 2);
    end
    send({2'b10, 6'h05, 12'h000, 4'h3});
    check({mainPowerUp, mainPumpDriveEn}, 2'b00);
    send({1'b1, 19'h0, 4'hF});
    r = xs();
    send({1'b1, r[18:0], 4'h5});
    check({auxPowerUp, auxFeedbackWord}, {1'b0, r[18:0]});
    freq(80, 0);
    check({mainPowerUp, auxPowerUp}, 2'b11);
    @(posedge clk);
    #1 chipEnable = 0;
    repeat (6) @(posedge clk);
    check({mainPowerUp, auxPowerUp}, 2'b00);
    #1 chipEnable = 1;
    send({1'b0, 19'h0, 4'hF});
    check({mainPowerUp, auxPowerUp}, 2'b01);
    send({20'hFFFFF, 4'h9});
    check(mainRefDiv, 6'h05);
    check(24'(q.size() + fq.size()), 24'd0);
    print_verdict();
  end
endmodule // rfdpc_top_bench
`default_nettype wire
